// *** nca_exec.sv ***
// Purpose: Executes the load, table, add, rotate, bit and compare instructions.
// Assumes: Fetch offers one word a cycle with instr_valid, and holds while hold_fetch_q.
// Notes: Memory nibble is read combinationally from the core; writes are registered.
//
// Functional notes
// (RULE1) Immediate load writes operand into accumulator.
// (RULE2) Consecutive immediate loads: only the first executes.
// (RULE3) Table address: page, low pointer bits, accumulator.
// (RULE4) Table word bits 7-4 to B, 3-0 to accumulator.
// (RULE5) Extension flag set: bits 9-8 to pointer low.
// (RULE6) Table reference uses one stack level; software keeps one.
// (RULE7) Plain add: memory plus accumulator, carry untouched.
// (RULE8) Add with carry updates accumulator and carry.
// (RULE9) Bit set forces selected memory bit to one.
// (RULE10) Bit clear forces selected memory bit to zero.
// (RULE11) Bit test skips when selected bit is zero.
// (RULE12) Compare skips on equality; immediate form takes two words.
// (RULE13) Complement inverts the accumulator.
// (RULE14) Rotate right through carry.
// (RULE15) Skip request passes over next instruction.
// (RULE16) Other instructions: one word, one cycle.
// (RULE17) Table reference pushes and restores the program counter.
`timescale 1ns/1ps
module nca_exec (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Instruction stream.
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    output logic hold_fetch_q,
    // Mode input.
    input wire logic table_pointer_extension_flag,
    // Program memory table read.
    output logic rom_rd_q,
    output logic [12:0] rom_addr_q,
    input wire logic [9:0] rom_data,
    // Data memory at the current data pointer.
    input wire logic [3:0] mem_nibble,
    output logic mem_we_q,
    output logic [3:0] mem_wdata_q,
    // Return stack control.
    output logic stack_push_q,
    output logic stack_pop_q,
    output logic [2:0] stack_pointer_q,
    output logic stack_overflow_q,
    // Architectural registers.
    output logic [3:0] acc_q,
    output logic carry_flag_q,
    output logic [3:0] reg_b_q,
    output logic [2:0] data_pointer_low_bits_q,
    // Sequencing status.
    output logic skip_q
);

    nca_pkg::nca_state_t state_q;
    nca_pkg::nca_state_t state_d;
    logic la_run_q;
    logic la_run_d;
    logic cmp_discard_q;
    logic cmp_discard_d;
    logic skip_d;
    logic hold_fetch_d;
    logic rom_rd_d;
    logic [12:0] rom_addr_d;
    logic mem_we_d;
    logic [3:0] mem_wdata_d;
    logic stack_push_d;
    logic stack_pop_d;
    logic [2:0] stack_pointer_d;
    logic stack_overflow_d;
    logic [3:0] acc_d;
    logic carry_flag_d;
    logic [3:0] reg_b_d;
    logic [2:0] data_pointer_low_bits_d;

    nca_pkg::nca_alu_op_t alu_op;
    logic [3:0] alu_acc;
    logic alu_carry;
    logic [3:0] alu_mem;
    logic alu_mem_we;
    logic alu_skip;
    logic is_load_imm;
    logic is_table_ref;
    logic is_cmp_imm_first;
    logic skip_now;
    logic exec_word;
    logic exec_alu;
    logic table_start;
    logic table_load;

    // True when the fixed bits of a word match an opcode.
    function automatic logic op_match(input logic [9:0] word, input logic [9:0] code,
                                      input logic [9:0] mask);
        op_match = ((word & mask) == code);
    endfunction

    // Maps a single-word instruction to its data path operation.
    function automatic nca_pkg::nca_alu_op_t decode_op(input logic [9:0] word);
        if (op_match(word, nca_pkg::OP_LOAD_IMM, nca_pkg::MASK_NIB_IMM)) begin
            decode_op = nca_pkg::NCA_OP_LOAD_IMM;
        end else if (word == nca_pkg::OP_ADD_MEM) begin
            decode_op = nca_pkg::NCA_OP_ADD_MEM;
        end else if (word == nca_pkg::OP_ADD_MEM_C) begin
            decode_op = nca_pkg::NCA_OP_ADD_MEM_C;
        end else if (word == nca_pkg::OP_CPL_ACC) begin
            decode_op = nca_pkg::NCA_OP_CPL;
        end else if (word == nca_pkg::OP_ROR_ACC) begin
            decode_op = nca_pkg::NCA_OP_ROR;
        end else if (op_match(word, nca_pkg::OP_SET_BIT, nca_pkg::MASK_BIT_IMM)) begin
            decode_op = nca_pkg::NCA_OP_SET_BIT;
        end else if (op_match(word, nca_pkg::OP_CLR_BIT, nca_pkg::MASK_BIT_IMM)) begin
            decode_op = nca_pkg::NCA_OP_CLR_BIT;
        end else if (op_match(word, nca_pkg::OP_TEST_BIT, nca_pkg::MASK_BIT_IMM)) begin
            decode_op = nca_pkg::NCA_OP_TEST_BIT;
        end else if (word == nca_pkg::OP_SKIP_EQ_MEM) begin
            decode_op = nca_pkg::NCA_OP_CMP_MEM;
        end else begin
            decode_op = nca_pkg::NCA_OP_NONE;
        end
    endfunction

    always_comb begin
        is_load_imm = op_match(instr_word, nca_pkg::OP_LOAD_IMM, nca_pkg::MASK_NIB_IMM);
        is_table_ref = op_match(instr_word, nca_pkg::OP_TABLE_REF, nca_pkg::MASK_PAGE_IMM);
        is_cmp_imm_first = (instr_word == nca_pkg::OP_SKIP_EQ_IMM1);
        // A pending skip or a repeated immediate load passes the word over.
        skip_now = skip_q | (is_load_imm & la_run_q); // RULE2 RULE15
        // A word executes only when taken in the execute state and not passed over.
        exec_word = (state_q == nca_pkg::NCA_ST_EXEC) && instr_valid && !skip_now;
        exec_alu = exec_word && !is_table_ref && !is_cmp_imm_first;
        table_start = exec_word && is_table_ref; // RULE6
        table_load = (state_q == nca_pkg::NCA_ST_TAB_LOAD);
        if (state_q == nca_pkg::NCA_ST_CMP_IMM) begin
            alu_op = nca_pkg::NCA_OP_CMP_IMM;
        end else if (state_q == nca_pkg::NCA_ST_EXEC && instr_valid && !skip_now) begin
            alu_op = decode_op(instr_word); // RULE16
        end else begin
            alu_op = nca_pkg::NCA_OP_NONE;
        end
    end

    nca_alu u_alu (
        .op(alu_op),
        .imm(instr_word[nca_pkg::IMM_LSB +: 4]),
        .bit_sel(instr_word[nca_pkg::BIT_SEL_LSB +: 2]),
        .acc(acc_q),
        .carry(carry_flag_q),
        .mem(mem_nibble),
        .acc_o(alu_acc),
        .carry_o(alu_carry),
        .mem_o(alu_mem),
        .mem_we_o(alu_mem_we),
        .skip_o(alu_skip)
    );

    // Sequencing: state, immediate-load run, compare discard, skip and fetch hold.
    always_comb begin
        state_d = state_q;
        la_run_d = la_run_q;
        cmp_discard_d = cmp_discard_q;
        skip_d = skip_q;
        unique case (state_q)
            nca_pkg::NCA_ST_EXEC: begin
                if (instr_valid) begin
                    la_run_d = is_load_imm; // RULE2
                    skip_d = 1'b0; // RULE15
                    if (is_cmp_imm_first) begin
                        // A skipped two-word compare must also swallow its second word.
                        state_d = nca_pkg::NCA_ST_CMP_IMM; // RULE12
                        cmp_discard_d = skip_now;
                    end else if (table_start) begin
                        state_d = nca_pkg::NCA_ST_TAB_READ;
                    end else if (!skip_now) begin
                        skip_d = alu_skip; // RULE11 RULE12
                    end
                end
            end
            nca_pkg::NCA_ST_TAB_READ: begin
                state_d = nca_pkg::NCA_ST_TAB_LOAD;
            end
            nca_pkg::NCA_ST_TAB_LOAD: begin
                state_d = nca_pkg::NCA_ST_EXEC;
            end
            nca_pkg::NCA_ST_CMP_IMM: begin
                if (instr_valid) begin
                    la_run_d = 1'b0;
                    skip_d = alu_skip & ~cmp_discard_q; // RULE12
                    cmp_discard_d = 1'b0;
                    state_d = nca_pkg::NCA_ST_EXEC;
                end
            end
            default: begin
                state_d = nca_pkg::NCA_ST_EXEC;
            end
        endcase
        // Fetch waits through both table cycles so the pushed return point stays put.
        hold_fetch_d = (state_d == nca_pkg::NCA_ST_TAB_READ) ||
                       (state_d == nca_pkg::NCA_ST_TAB_LOAD);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= nca_pkg::NCA_ST_EXEC;
            la_run_q <= 1'b0;
            cmp_discard_q <= 1'b0;
            skip_q <= 1'b0;
            hold_fetch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            la_run_q <= la_run_d;
            cmp_discard_q <= cmp_discard_d;
            skip_q <= skip_d;
            hold_fetch_q <= hold_fetch_d;
        end
    end

    // Table bus and return stack: one push on entry, one pop in the load cycle.
    always_comb begin
        rom_rd_d = 1'b0;
        rom_addr_d = rom_addr_q;
        stack_push_d = 1'b0;
        stack_pop_d = 1'b0;
        stack_pointer_d = stack_pointer_q;
        stack_overflow_d = stack_overflow_q;
        if (table_start) begin
            stack_push_d = 1'b1; // RULE6 RULE17
            stack_pointer_d = stack_pointer_q + 3'h1; // RULE6
            // Overflow is sticky so that a lost return point stays visible.
            if (stack_pointer_q == 3'(nca_pkg::STACK_LEVELS - 1)) begin
                stack_overflow_d = 1'b1;
            end
            rom_rd_d = 1'b1;
            rom_addr_d = {instr_word[nca_pkg::PAGE_W-1:0],
                          data_pointer_low_bits_q, acc_q}; // RULE3
        end else if (table_load) begin
            // The pop hands the return point pushed on entry back to the core.
            stack_pop_d = 1'b1; // RULE17
            stack_pointer_d = stack_pointer_q - 3'h1; // RULE6
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rom_rd_q <= 1'b0;
            rom_addr_q <= 13'h0;
            stack_push_q <= 1'b0;
            stack_pop_q <= 1'b0;
            stack_pointer_q <= nca_pkg::SP_RST;
            stack_overflow_q <= 1'b0;
        end else begin
            rom_rd_q <= rom_rd_d;
            rom_addr_q <= rom_addr_d;
            stack_push_q <= stack_push_d;
            stack_pop_q <= stack_pop_d;
            stack_pointer_q <= stack_pointer_d;
            stack_overflow_q <= stack_overflow_d;
        end
    end

    // Architectural registers and the data memory write port.
    always_comb begin
        mem_we_d = 1'b0;
        mem_wdata_d = mem_wdata_q;
        acc_d = acc_q;
        carry_flag_d = carry_flag_q;
        reg_b_d = reg_b_q;
        data_pointer_low_bits_d = data_pointer_low_bits_q;
        if (exec_alu) begin
            acc_d = alu_acc;
            carry_flag_d = alu_carry;
            // The write is registered: a read in the very next cycle sees the old nibble.
            mem_we_d = alu_mem_we;
            mem_wdata_d = alu_mem;
        end else if (table_load) begin
            reg_b_d = rom_data[nca_pkg::ROM_HI_LSB +: 4]; // RULE4
            acc_d = rom_data[3:0]; // RULE4
            if (table_pointer_extension_flag) begin
                data_pointer_low_bits_d = {1'b0, rom_data[nca_pkg::ROM_D_LSB +: 2]}; // RULE5
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_we_q <= 1'b0;
            mem_wdata_q <= 4'h0;
            acc_q <= nca_pkg::ACC_RST;
            carry_flag_q <= nca_pkg::CARRY_RST;
            reg_b_q <= nca_pkg::REG_B_RST;
            data_pointer_low_bits_q <= nca_pkg::DLOW_RST;
        end else begin
            mem_we_q <= mem_we_d;
            mem_wdata_q <= mem_wdata_d;
            acc_q <= acc_d;
            carry_flag_q <= carry_flag_d;
            reg_b_q <= reg_b_d;
            data_pointer_low_bits_q <= data_pointer_low_bits_d;
        end
    end

endmodule

// *** nca_pkg.sv ***
// Purpose: Shared constants and types for the nibble core execution group.
// Assumes: 10-bit program words, 4-bit data words, one instruction clock.
// Notes: Opcode values and masks are compared against the full program word.
package nca_pkg;

    // Word widths.
    localparam int unsigned WORD_W = 10;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned PAGE_W = 6;
    localparam int unsigned DLOW_W = 3;
    localparam int unsigned ROM_AW = PAGE_W + DLOW_W + NIB_W;
    localparam int unsigned SP_W = 3;
    localparam int unsigned STACK_LEVELS = 8;

    // Fixed opcodes; OP_SKIP_EQ_IMM1 is the first word of a two-word compare.
    localparam logic [9:0] OP_ADD_MEM = 10'h00a;
    localparam logic [9:0] OP_ADD_MEM_C = 10'h00b;
    localparam logic [9:0] OP_CPL_ACC = 10'h01c;
    localparam logic [9:0] OP_ROR_ACC = 10'h01d;
    localparam logic [9:0] OP_SKIP_EQ_MEM = 10'h026;
    localparam logic [9:0] OP_SKIP_EQ_IMM1 = 10'h025;

    // Opcodes with an immediate field: code and the mask of fixed bits.
    localparam logic [9:0] OP_LOAD_IMM = 10'h070;
    localparam logic [9:0] MASK_NIB_IMM = 10'h3f0;
    localparam logic [9:0] OP_SET_BIT = 10'h05c;
    localparam logic [9:0] OP_CLR_BIT = 10'h04c;
    localparam logic [9:0] OP_TEST_BIT = 10'h020;
    localparam logic [9:0] MASK_BIT_IMM = 10'h3fc;
    localparam logic [9:0] OP_TABLE_REF = 10'h080;
    localparam logic [9:0] MASK_PAGE_IMM = 10'h3c0;

    // Field positions inside words.
    localparam int unsigned IMM_LSB = 0;
    localparam int unsigned BIT_SEL_LSB = 0;
    localparam int unsigned ROM_HI_LSB = 4;
    localparam int unsigned ROM_D_LSB = 8;

    // Reset values.
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [3:0] REG_B_RST = 4'h0;
    localparam logic [2:0] DLOW_RST = 3'h0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [2:0] SP_RST = 3'h0;

    // Cycle counts.
    localparam int unsigned TABLE_REF_CYCLES = 3;
    localparam int unsigned CMP_IMM_CYCLES = 2;

    typedef enum logic [3:0] {
        NCA_OP_NONE = 4'h0,
        NCA_OP_LOAD_IMM = 4'h1,
        NCA_OP_ADD_MEM = 4'h2,
        NCA_OP_ADD_MEM_C = 4'h3,
        NCA_OP_CPL = 4'h4,
        NCA_OP_ROR = 4'h5,
        NCA_OP_SET_BIT = 4'h6,
        NCA_OP_CLR_BIT = 4'h7,
        NCA_OP_TEST_BIT = 4'h8,
        NCA_OP_CMP_MEM = 4'h9,
        NCA_OP_CMP_IMM = 4'ha
    } nca_alu_op_t;

    typedef enum logic [3:0] {
        NCA_ST_EXEC = 4'b0001,
        NCA_ST_TAB_READ = 4'b0010,
        NCA_ST_TAB_LOAD = 4'b0100,
        NCA_ST_CMP_IMM = 4'b1000
    } nca_state_t;

endpackage

// *** nca_alu.sv ***
// Purpose: Combinational data path for the accumulator, carry and memory nibble.
// Assumes: Operands are stable for the whole cycle in which op is presented.
// Notes: Has no state; the sequencer registers every result.
`timescale 1ns/1ps
module nca_alu (
    // Operation.
    input wire nca_pkg::nca_alu_op_t op,
    input wire logic [3:0] imm,
    input wire logic [1:0] bit_sel,
    // Operands.
    input wire logic [3:0] acc,
    input wire logic carry,
    input wire logic [3:0] mem,
    // Results.
    output logic [3:0] acc_o,
    output logic carry_o,
    output logic [3:0] mem_o,
    output logic mem_we_o,
    output logic skip_o
);

    logic [4:0] sum;
    logic [3:0] bit_mask;

    always_comb begin
        sum = 5'h0;
        bit_mask = 4'h1 << bit_sel;
        acc_o = acc;
        carry_o = carry;
        mem_o = mem;
        mem_we_o = 1'b0;
        skip_o = 1'b0;
        unique case (op)
            nca_pkg::NCA_OP_NONE: begin
            end
            nca_pkg::NCA_OP_LOAD_IMM: begin
                acc_o = imm; // RULE1
            end
            nca_pkg::NCA_OP_ADD_MEM: begin
                sum = {1'b0, acc} + {1'b0, mem};
                acc_o = sum[3:0]; // RULE7
            end
            nca_pkg::NCA_OP_ADD_MEM_C: begin
                sum = {1'b0, acc} + {1'b0, mem} + {4'h0, carry};
                acc_o = sum[3:0]; // RULE8
                carry_o = sum[4]; // RULE8
            end
            nca_pkg::NCA_OP_CPL: begin
                acc_o = ~acc; // RULE13
            end
            nca_pkg::NCA_OP_ROR: begin
                acc_o = {carry, acc[3:1]}; // RULE14
                carry_o = acc[0]; // RULE14
            end
            nca_pkg::NCA_OP_SET_BIT: begin
                mem_o = mem | bit_mask; // RULE9
                mem_we_o = 1'b1;
            end
            nca_pkg::NCA_OP_CLR_BIT: begin
                mem_o = mem & ~bit_mask; // RULE10
                mem_we_o = 1'b1;
            end
            nca_pkg::NCA_OP_TEST_BIT: begin
                skip_o = ((mem & bit_mask) == 4'h0); // RULE11
            end
            nca_pkg::NCA_OP_CMP_MEM: begin
                skip_o = (acc == mem); // RULE12
            end
            nca_pkg::NCA_OP_CMP_IMM: begin
                skip_o = (acc == imm); // RULE12
            end
            default: begin
            end
        endcase
    end

endmodule

// *** nca_exec_properties.sv ***
// Purpose: Port-level checks for the execution group.
// Assumes: One clock; reset is asynchronous and active low.
// Notes: Checks start from a word that is taken and not skipped.
`timescale 1ns/1ps
module nca_exec_properties (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Instruction stream.
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic hold_fetch_q,
    // Memory and table.
    input wire logic [3:0] mem_nibble,
    input wire logic mem_we_q,
    input wire logic [3:0] mem_wdata_q,
    input wire logic rom_rd_q,
    input wire logic [12:0] rom_addr_q,
    input wire logic stack_push_q,
    input wire logic stack_pop_q,
    // State.
    input wire logic [3:0] acc_q,
    input wire logic carry_flag_q,
    input wire logic [2:0] data_pointer_low_bits_q,
    input wire logic skip_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic cmp2_q;
    logic ex;
    // The word after a compare-immediate opcode is an operand, not an instruction.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmp2_q <= 1'b0;
        end else if (instr_valid && !hold_fetch_q) begin
            cmp2_q <= !cmp2_q && instr_word == 10'h025;
        end
    end
    assign ex = instr_valid && !hold_fetch_q && !skip_q && !cmp2_q;
    a_add_plain: assert property (ex && instr_word == 10'h00a |=>
        acc_q == 4'($past(acc_q + mem_nibble)) && $stable(carry_flag_q))
        else $error("plain add wrong");
    a_add_carry: assert property (ex && instr_word == 10'h00b |=>
        {carry_flag_q, acc_q} == $past({1'b0, acc_q} + mem_nibble + carry_flag_q))
        else $error("add with carry wrong");
    a_rotate_right: assert property (ex && instr_word == 10'h01d |=>
        {acc_q, carry_flag_q} == $past({carry_flag_q, acc_q}))
        else $error("rotate wrong");
    a_bit_set: assert property (ex && (instr_word & 10'h3fc) == 10'h05c |=>
        mem_we_q && mem_wdata_q == $past(mem_nibble | 4'(1 << instr_word[1:0])))
        else $error("bit set wrong");
    a_bit_test: assert property (ex && (instr_word & 10'h3fc) == 10'h020 |=>
        skip_q == $past(!mem_nibble[instr_word[1:0]]))
        else $error("bit test wrong");
    a_mem_compare: assert property (ex && instr_word == 10'h026 |=>
        skip_q == $past(acc_q == mem_nibble))
        else $error("memory compare wrong");
    a_table_walk: assert property (ex && (instr_word & 10'h3c0) == 10'h080 |=>
        rom_rd_q && stack_push_q && hold_fetch_q ##1 hold_fetch_q && !rom_rd_q
        ##1 stack_pop_q && !hold_fetch_q) else $error("table sequence wrong");
    a_table_addr: assert property (ex && (instr_word & 10'h3c0) == 10'h080 |=>
        rom_addr_q == $past({instr_word[5:0], data_pointer_low_bits_q, acc_q}))
        else $error("table address wrong");
endmodule
bind nca_exec nca_exec_properties u_props (.clk, .arst_n, .instr_valid, .instr_word,
    .hold_fetch_q, .mem_nibble, .mem_we_q, .mem_wdata_q, .rom_rd_q, .rom_addr_q,
    .stack_push_q, .stack_pop_q, .acc_q, .carry_flag_q, .data_pointer_low_bits_q, .skip_q);

// *** nca_mem_model.sv ***
// Purpose: Program table and data nibble seen by the execution group.
// Assumes: Table data is registered one cycle after the read strobe.
// Notes: The idle table bus toggles so stale data never looks valid.
`timescale 1ns/1ps
module nca_mem_model (
    // Clock.
    input wire logic clk,
    // Table port.
    input wire logic rom_rd_q,
    input wire logic [12:0] rom_addr_q,
    output logic [9:0] rom_data,
    // Data nibble port.
    input wire logic mem_we_q,
    input wire logic [3:0] mem_wdata_q,
    input wire logic ram_ld,
    input wire logic [3:0] ram_val,
    output logic [3:0] mem_nibble
);
    function automatic logic [9:0] rom_fn(logic [12:0] a);
        return a[9:0] ^ {a[3:0], a[12:7]};
    endfunction
    initial rom_data = 10'h155;
    initial mem_nibble = 4'h0;
    always @(posedge clk) begin
        rom_data <= rom_rd_q ? rom_fn(rom_addr_q) : ~rom_data;
        if (ram_ld) mem_nibble <= ram_val;
        else if (mem_we_q) mem_nibble <= mem_wdata_q;
    end
endmodule

// *** nibble_cpu_alu_bit_compare_exec_test.sv ***
// Purpose: Self-checking bench comparing the execution group with a reference model.
// Assumes: 8 ns clock; inputs change 1 ns after the rising edge.
// Notes: The model delays data memory writes by one cycle, as the core does.
`timescale 1ns/1ps
module nibble_cpu_alu_bit_compare_exec_test;
    logic clk, arst_n, iv, flag, ram_ld, hold, rd, we, push, pop, ovf, cy, skip;
    logic [9:0] w, rom, x;
    logic [12:0] addr, m_addr;
    logic [3:0] ram_val, mem, wd, acc, b, m_acc, m_b, m_mem, m_pv;
    logic [2:0] sp, d, m_d, m_sp;
    logic m_cy, m_skip, m_la, m_cmp, m_dead, m_pw, m_rd, m_push, m_pop;
    int err_total = 0, check_count = 0, seed = 67026, ncyc = 0, m_hold = 0, k;
    nca_exec uut (.clk, .arst_n, .instr_valid(iv), .instr_word(w), .hold_fetch_q(hold),
        .table_pointer_extension_flag(flag), .rom_rd_q(rd), .rom_addr_q(addr),
        .rom_data(rom), .mem_nibble(mem), .mem_we_q(we), .mem_wdata_q(wd),
        .stack_push_q(push), .stack_pop_q(pop), .stack_pointer_q(sp),
        .stack_overflow_q(ovf), .acc_q(acc), .carry_flag_q(cy), .reg_b_q(b),
        .data_pointer_low_bits_q(d), .skip_q(skip));
    nca_mem_model u_mem (.clk, .rom_rd_q(rd), .rom_addr_q(addr), .rom_data(rom),
        .mem_we_q(we), .mem_wdata_q(wd), .ram_ld, .ram_val, .mem_nibble(mem));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        ncyc <= ncyc + 1;
        if (ncyc == 3000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(string n, logic [12:0] e, logic [12:0] g);
        check_count++;
        if (e !== g) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic step();
        logic [3:0] r;
        logic [9:0] t;
        r = m_mem;
        if (m_pw) m_mem = m_pv;
        if (ram_ld) m_mem = ram_val;
        {m_pw, m_rd, m_push, m_pop} = 4'h0;
        if (m_hold == 2) begin
            m_hold = 1;
        end else if (m_hold == 1) begin
            t = u_mem.rom_fn(m_addr);
            {m_b, m_acc} = t[7:0];
            if (flag) m_d = {1'b0, t[9:8]};
            m_sp--;
            m_pop = 1'b1;
            m_hold = 0;
        end else if (iv && m_cmp) begin
            m_skip = !m_dead && m_acc == w[3:0];
            m_cmp = 1'b0;
            m_la = 1'b0;
        end else if (iv && m_skip) begin
            m_skip = 1'b0;
            m_cmp = w == 10'h025;
            m_dead = 1'b1;
            m_la = w[9:4] == 6'h07;
        end else if (iv) begin
            m_skip = 1'b0;
            if (w[9:4] == 6'h07) begin
                if (!m_la) m_acc = w[3:0];
                m_la = 1'b1;
            end else begin
                m_la = 1'b0;
                casez (w)
                    10'h00a: m_acc = m_acc + r;
                    10'h00b: {m_cy, m_acc} = m_acc + r + m_cy;
                    10'h01c: m_acc = ~m_acc;
                    10'h01d: {m_acc, m_cy} = {m_cy, m_acc};
                    10'h026: m_skip = m_acc == r;
                    10'h025: {m_cmp, m_dead} = 2'b10;
                    10'b00001000??: m_skip = !r[w[1:0]];
                    10'b00010?11??: begin
                        m_pw = 1'b1;
                        m_pv = w[4] ? r | 4'(1 << w[1:0]) : r & ~4'(1 << w[1:0]);
                    end
                    10'b0010??????: begin
                        m_addr = {w[5:0], m_d, m_acc};
                        m_sp++;
                        {m_rd, m_push} = 2'b11;
                        m_hold = 2;
                    end
                    default: ;
                endcase
            end
        end
    endtask
    task automatic cyc(logic v, logic [9:0] word, logic ld = 1'b0, logic [3:0] lv = 4'h0);
        iv = v;
        w = word;
        ram_ld = ld;
        ram_val = lv;
        flag = 1'($random(seed));
        @(posedge clk);
        step();
        #1;
        chk("acc", m_acc, acc);
        chk("carry", m_cy, cy);
        chk("regb", m_b, b);
        chk("dlow", m_d, d);
        chk("skip", m_skip, skip);
        chk("mem", m_mem, mem);
        chk("we", m_pw, we);
        if (m_pw) chk("wdata", m_pv, wd);
        chk("table", {m_rd, m_push, m_pop, m_hold != 0}, {rd, push, pop, hold});
        if (m_rd) chk("addr", m_addr, addr);
        chk("stack", m_sp, {ovf, sp});
    endtask
    initial begin
        {arst_n, iv, w, flag, ram_ld, ram_val, m_acc, m_b, m_mem, m_pv, m_d, m_sp} = '0;
        {m_cy, m_skip, m_la, m_cmp, m_dead, m_pw, m_rd, m_push, m_pop, m_addr} = '0;
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        cyc(0, 10'h000, 1'b1, 4'h9);
        cyc(1, 10'h073);
        cyc(1, 10'h075);
        cyc(1, 10'h07e);
        cyc(1, 10'h00a);
        repeat (400) begin
            k = $unsigned($random(seed)) % 12;
            x = 10'($random(seed));
            case (k)
                0: cyc(1, {6'h07, x[3:0]});
                1: cyc(1, 10'h00a);
                2: cyc(1, 10'h00b);
                3: cyc(1, 10'h01c);
                4: cyc(1, 10'h01d);
                5: cyc(1, {5'b00010, x[4], 2'b11, x[1:0]});
                6: cyc(1, {8'h08, x[1:0]});
                7: cyc(1, 10'h026);
                8: begin
                    cyc(1, 10'h025);
                    cyc(1, {6'h07, x[5] ? m_acc : x[3:0]});
                end
                9: begin
                    // Tables are never nested, so a stack level stays free.
                    cyc(1, {4'h2, x[5:0]});
                    cyc(1, x);
                    cyc(0, x);
                end
                10: cyc(0, x, 1'b1, x[9] ? m_acc : x[3:0]);
                default: cyc(x[9], 10'h3ff);
            endcase
        end
        complete_run();
    end
endmodule
